/* File: verilog/bmpr_pkg.sv */
package bmpr_pkg;

    // operating modes, gray along off -> setup -> running -> quiet
    typedef enum logic [1:0]
    {
        BMPR_MODE_OFF = 2'h0,
        BMPR_MODE_SETUP = 2'h1,
        BMPR_MODE_RUN = 2'h3,
        BMPR_MODE_QUIET = 2'h2
    } bmpr_mode_type;

    localparam int BMPR_ADDR_W = 7;
    localparam int BMPR_DATA_W = 8;

    // register addresses
    localparam logic [6:0] BMPR_ADDR_CONTROL = 7'h00;
    localparam logic [6:0] BMPR_ADDR_GATE_DRIVER_ACTIVATE = 7'h01;
    localparam logic [6:0] BMPR_ADDR_GATE_OUTPUT_ASSOCIATION = 7'h02;
    localparam logic [6:0] BMPR_ADDR_STATUS = 7'h03;
    localparam logic [6:0] BMPR_ADDR_VPHASE_ENABLE_OUT_ONE = 7'h0b;
    localparam logic [6:0] BMPR_ADDR_VPHASE_ENABLE_OUT_TWO = 7'h0c;
    localparam logic [6:0] BMPR_ADDR_GATE_PHASE_OUTPUT_ASSIGN = 7'h0f;
    localparam logic [6:0] BMPR_ADDR_VIRTUAL_PHASE_ROUTING = 7'h10;

    // control register fields
    localparam int BMPR_CTRL_SETUP_FINISHED_BIT = 0;
    localparam int BMPR_CTRL_OUTPUT_ONE_TURN_ON = 1;
    localparam int BMPR_CTRL_OUTPUT_TWO_TURN_ON = 2;

    // status register fields
    localparam int BMPR_STAT_GATE_SUPPLY_GOOD = 0;
    localparam int BMPR_STAT_MODE_LSB = 1;

    // field widths and reset values
    localparam int BMPR_NUM_GATES = 2;
    localparam int BMPR_NUM_VPHASES = 4;
    localparam int BMPR_PICK_W = 2;
    localparam logic [1:0] BMPR_GATE_BITS_RST = 2'h0;
    localparam logic [3:0] BMPR_VPHASE_BITS_RST = 4'h0;
    localparam logic [3:0] BMPR_ROUTING_RST = 4'h0;
    localparam logic [7:0] BMPR_UNMAPPED_READ = 8'h00;

    // spi frame: rw bit, 7 address bits, 8 data bits, msb first
    localparam int BMPR_SPI_CNT_W = 5;
    localparam logic [4:0] BMPR_SPI_HDR_LAST = 5'h07;
    localparam logic [4:0] BMPR_SPI_DATA_FIRST = 5'h08;
    localparam logic [4:0] BMPR_SPI_FRAME_LAST = 5'h0f;
    localparam logic [4:0] BMPR_SPI_FRAME_BITS = 5'h10;
    localparam logic [4:0] BMPR_SPI_CNT_ONE = 5'h01;

endpackage : bmpr_pkg

/* File: verilog/bmpr_reg_if.sv */
interface bmpr_reg_if;
    logic wr_stb;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport slave
    (
        output wr_stb,
        output addr,
        output wdata,
        input rdata
    );

    modport bank
    (
        input wr_stb,
        input addr,
        input wdata,
        output rdata
    );
endinterface : bmpr_reg_if

/* File: verilog/bmpr_spi_slave.sv */
module bmpr_spi_slave
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    input wire logic i_enable,
    input wire logic i_spi_sclk,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_mosi,
    output logic o_spi_miso,
    output logic o_spi_miso_oe,
    bmpr_reg_if.slave bus
);

    logic sclk_q_r;
    logic [4:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic cmd_write_r;
    logic [6:0] addr_r;
    logic [7:0] wdata_r;
    logic wr_stb_r;
    logic frame_on;
    logic sclk_rise;
    logic sclk_fall;

    // sclk is sampled by the core clock, so it must run well below 20 MHz
    assign frame_on = i_enable && !i_spi_cs_n;
    assign sclk_rise = frame_on && i_spi_sclk && !sclk_q_r;
    assign sclk_fall = frame_on && !i_spi_sclk && sclk_q_r;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            sclk_q_r <= 1'b0;
        else if (i_clk_en)
            sclk_q_r <= i_spi_sclk;
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            bit_cnt_r <= '0;
            shift_r <= '0;
            cmd_write_r <= 1'b0;
            addr_r <= '0;
        end
        else if (i_clk_en)
        begin
            if (!frame_on)
                bit_cnt_r <= '0;
            else if (sclk_rise && bit_cnt_r != bmpr_pkg::BMPR_SPI_FRAME_BITS)
            begin
                // bits past the sixteenth are ignored
                shift_r <= {shift_r[6:0], i_spi_mosi};
                bit_cnt_r <= bit_cnt_r + bmpr_pkg::BMPR_SPI_CNT_ONE;
                if (bit_cnt_r == bmpr_pkg::BMPR_SPI_HDR_LAST)
                begin
                    cmd_write_r <= shift_r[6];
                    addr_r <= {shift_r[5:0], i_spi_mosi};
                end
            end
        end
    end

    // write strobe only on a complete frame
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wr_stb_r <= 1'b0;
            wdata_r <= '0;
        end
        else if (i_clk_en)
        begin
            wr_stb_r <= 1'b0;
            if (sclk_rise && bit_cnt_r == bmpr_pkg::BMPR_SPI_FRAME_LAST)
            begin
                wr_stb_r <= cmd_write_r;
                wdata_r <= {shift_r[6:0], i_spi_mosi};
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            tx_r <= '0;
        else if (i_clk_en)
        begin
            if (!frame_on)
                tx_r <= '0;
            else if (sclk_fall && bit_cnt_r == bmpr_pkg::BMPR_SPI_DATA_FIRST)
                tx_r <= bus.rdata;
            else if (sclk_fall && bit_cnt_r > bmpr_pkg::BMPR_SPI_DATA_FIRST)
                tx_r <= {tx_r[6:0], 1'b0};
        end
    end

    assign o_spi_miso = tx_r[7];
    assign o_spi_miso_oe = frame_on;
    assign bus.wr_stb = wr_stb_r;
    assign bus.addr = addr_r;
    assign bus.wdata = wdata_r;

endmodule : bmpr_spi_slave

/* File: verilog/bmpr_top.sv */
// Summary of operation
// - leave off for setup when supply is detected and chip activate is high.
// - configuration registers accept spi writes during setup.
// - setting the setup finished bit enters running and locks configuration.
// - in running, either output turn-on bit starts the gate drive supply.
// - each boost output turns on only once gate supply good is seen.
// - battery monitoring is enabled only while converters are running.
// - over-temperature or gate supply error moves running to fail-safe quiet.
// - input under- or over-voltage during running moves to fail-safe quiet.
// - fail-safe quiet forces all gates off, spi keeps working.
// - four virtual phases shared by two outputs, chosen per output enables.
// - output one phase enable bits 3..0 enable virtual phases four..one.
// - output two phase enable bits 3..0 enable virtual phases four..one.
// - association bits 1,0 tie physical phases two,one to output two or one.
// - gate phase assign bits 1,0 pick the output for phases two,one.
// - routing bits 3:2 and 1:0 pick virtual phase for drivers two, one.
// - gate activate bits 1,0 switch physical phases two,one on.
// - supply loss or chip activate low returns any state to off.
// - from quiet, toggling chip activate restarts; spi is held idle while it is low.
// - clearing the setup finished bit restores configuration write access.
module bmpr_top
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    input wire logic i_supply_detect,
    input wire logic i_chip_activate,
    input wire logic i_over_temp,
    input wire logic i_gate_supply_err,
    input wire logic i_gate_supply_good,
    input wire logic i_input_undervolt,
    input wire logic i_input_overvolt,
    input wire logic [3:0] i_vphase,
    input wire logic i_spi_sclk,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_mosi,
    output logic o_spi_miso,
    output logic o_spi_miso_oe,
    output logic [1:0] o_mode,
    output logic o_gate_drive_supply_on,
    output logic o_boost_output_one_on,
    output logic o_boost_output_two_on,
    output logic o_battery_monitor_on,
    output logic [1:0] o_gate_drive
);

    bmpr_pkg::bmpr_mode_type mode_r;
    bmpr_pkg::bmpr_mode_type mode_nxt;

    logic setup_finished_bit_r;
    logic output_one_turn_on_r;
    logic output_two_turn_on_r;
    logic [1:0] gate_driver_activate_r;
    logic [1:0] gate_output_association_r;
    logic [3:0] virtual_phase_enable_out_one_r;
    logic [3:0] virtual_phase_enable_out_two_r;
    logic [1:0] gate_phase_output_assign_r;
    logic [3:0] virtual_phase_routing_r;
    logic gate_drive_supply_on_r;
    logic boost_output_one_on_r;
    logic boost_output_two_on_r;
    logic battery_monitor_on_r;
    logic [1:0] gate_drive_r;

    logic powered;
    logic running;
    logic spi_enable;
    logic ctrl_wr;
    logic cfg_wr;
    logic cfg_locked;
    logic fault;
    logic [7:0] rdata;

    bmpr_reg_if reg_bus ();

    // spi held idle while powered down
    assign powered = i_supply_detect && i_chip_activate;
    assign running = (mode_r == bmpr_pkg::BMPR_MODE_RUN);
    assign spi_enable = (mode_r != bmpr_pkg::BMPR_MODE_OFF);

    bmpr_spi_slave u_spi
    (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_clk_en(i_clk_en),
        .i_enable(spi_enable),
        .i_spi_sclk(i_spi_sclk),
        .i_spi_cs_n(i_spi_cs_n),
        .i_spi_mosi(i_spi_mosi),
        .o_spi_miso(o_spi_miso),
        .o_spi_miso_oe(o_spi_miso_oe),
        .bus(reg_bus.slave)
    );

    assign fault = i_over_temp || i_gate_supply_err || i_input_undervolt || i_input_overvolt;

    always_comb
    begin
        mode_nxt = mode_r;
        unique case (mode_r)
            bmpr_pkg::BMPR_MODE_OFF:
            begin
                if (powered)
                    mode_nxt = bmpr_pkg::BMPR_MODE_SETUP;
            end
            bmpr_pkg::BMPR_MODE_SETUP:
            begin
                if (setup_finished_bit_r)
                    mode_nxt = bmpr_pkg::BMPR_MODE_RUN;
            end
            bmpr_pkg::BMPR_MODE_RUN:
            begin
                if (fault)
                    mode_nxt = bmpr_pkg::BMPR_MODE_QUIET;
                else if (!setup_finished_bit_r)
                    mode_nxt = bmpr_pkg::BMPR_MODE_SETUP;
            end
            bmpr_pkg::BMPR_MODE_QUIET:
            begin
                // left only through power loss or chip activate low
                mode_nxt = bmpr_pkg::BMPR_MODE_QUIET;
            end
        endcase
        if (!powered)
            mode_nxt = bmpr_pkg::BMPR_MODE_OFF;
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            mode_r <= bmpr_pkg::BMPR_MODE_OFF;
        else if (i_clk_en)
            mode_r <= mode_nxt;
    end

    // control bits writable in every powered mode
    assign ctrl_wr = reg_bus.wr_stb && spi_enable && (reg_bus.addr == bmpr_pkg::BMPR_ADDR_CONTROL);

    // lock follows the finished bit, so clearing it reopens writes even in quiet
    assign cfg_locked = setup_finished_bit_r;
    assign cfg_wr = reg_bus.wr_stb && spi_enable && !cfg_locked;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            setup_finished_bit_r <= 1'b0;
            output_one_turn_on_r <= 1'b0;
            output_two_turn_on_r <= 1'b0;
        end
        else if (i_clk_en)
        begin
            if (mode_r == bmpr_pkg::BMPR_MODE_OFF)
            begin
                // power-down loses all settings
                setup_finished_bit_r <= 1'b0;
                output_one_turn_on_r <= 1'b0;
                output_two_turn_on_r <= 1'b0;
            end
            else if (ctrl_wr)
            begin
                setup_finished_bit_r <= reg_bus.wdata[bmpr_pkg::BMPR_CTRL_SETUP_FINISHED_BIT];
                output_one_turn_on_r <= reg_bus.wdata[bmpr_pkg::BMPR_CTRL_OUTPUT_ONE_TURN_ON];
                output_two_turn_on_r <= reg_bus.wdata[bmpr_pkg::BMPR_CTRL_OUTPUT_TWO_TURN_ON];
            end
        end
    end

    // reserved upper bits are not stored and read back as zero
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            gate_driver_activate_r <= bmpr_pkg::BMPR_GATE_BITS_RST;
            gate_output_association_r <= bmpr_pkg::BMPR_GATE_BITS_RST;
            virtual_phase_enable_out_one_r <= bmpr_pkg::BMPR_VPHASE_BITS_RST;
            virtual_phase_enable_out_two_r <= bmpr_pkg::BMPR_VPHASE_BITS_RST;
            gate_phase_output_assign_r <= bmpr_pkg::BMPR_GATE_BITS_RST;
            virtual_phase_routing_r <= bmpr_pkg::BMPR_ROUTING_RST;
        end
        else if (i_clk_en)
        begin
            if (mode_r == bmpr_pkg::BMPR_MODE_OFF)
            begin
                gate_driver_activate_r <= bmpr_pkg::BMPR_GATE_BITS_RST;
                gate_output_association_r <= bmpr_pkg::BMPR_GATE_BITS_RST;
                virtual_phase_enable_out_one_r <= bmpr_pkg::BMPR_VPHASE_BITS_RST;
                virtual_phase_enable_out_two_r <= bmpr_pkg::BMPR_VPHASE_BITS_RST;
                gate_phase_output_assign_r <= bmpr_pkg::BMPR_GATE_BITS_RST;
                virtual_phase_routing_r <= bmpr_pkg::BMPR_ROUTING_RST;
            end
            else if (cfg_wr)
            begin
                unique case (reg_bus.addr)
                    bmpr_pkg::BMPR_ADDR_GATE_DRIVER_ACTIVATE:
                        gate_driver_activate_r <= reg_bus.wdata[1:0];
                    bmpr_pkg::BMPR_ADDR_GATE_OUTPUT_ASSOCIATION:
                        gate_output_association_r <= reg_bus.wdata[1:0];
                    bmpr_pkg::BMPR_ADDR_VPHASE_ENABLE_OUT_ONE:
                        virtual_phase_enable_out_one_r <= reg_bus.wdata[3:0];
                    bmpr_pkg::BMPR_ADDR_VPHASE_ENABLE_OUT_TWO:
                        virtual_phase_enable_out_two_r <= reg_bus.wdata[3:0];
                    bmpr_pkg::BMPR_ADDR_GATE_PHASE_OUTPUT_ASSIGN:
                        gate_phase_output_assign_r <= reg_bus.wdata[1:0];
                    bmpr_pkg::BMPR_ADDR_VIRTUAL_PHASE_ROUTING:
                        virtual_phase_routing_r <= reg_bus.wdata[3:0];
                    default:
                    begin
                        // control, status and unmapped addresses
                    end
                endcase
            end
        end
    end

    // read mux, sampled by the spi slave after the address byte
    always_comb
    begin
        rdata = bmpr_pkg::BMPR_UNMAPPED_READ;
        unique case (reg_bus.addr)
            bmpr_pkg::BMPR_ADDR_CONTROL:
            begin
                rdata[bmpr_pkg::BMPR_CTRL_SETUP_FINISHED_BIT] = setup_finished_bit_r;
                rdata[bmpr_pkg::BMPR_CTRL_OUTPUT_ONE_TURN_ON] = output_one_turn_on_r;
                rdata[bmpr_pkg::BMPR_CTRL_OUTPUT_TWO_TURN_ON] = output_two_turn_on_r;
            end
            bmpr_pkg::BMPR_ADDR_STATUS:
            begin
                rdata[bmpr_pkg::BMPR_STAT_GATE_SUPPLY_GOOD] = i_gate_supply_good;
                rdata[bmpr_pkg::BMPR_STAT_MODE_LSB +: 2] = mode_r;
            end
            bmpr_pkg::BMPR_ADDR_GATE_DRIVER_ACTIVATE:
                rdata[1:0] = gate_driver_activate_r;
            bmpr_pkg::BMPR_ADDR_GATE_OUTPUT_ASSOCIATION:
                rdata[1:0] = gate_output_association_r;
            bmpr_pkg::BMPR_ADDR_VPHASE_ENABLE_OUT_ONE:
                rdata[3:0] = virtual_phase_enable_out_one_r;
            bmpr_pkg::BMPR_ADDR_VPHASE_ENABLE_OUT_TWO:
                rdata[3:0] = virtual_phase_enable_out_two_r;
            bmpr_pkg::BMPR_ADDR_GATE_PHASE_OUTPUT_ASSIGN:
                rdata[1:0] = gate_phase_output_assign_r;
            bmpr_pkg::BMPR_ADDR_VIRTUAL_PHASE_ROUTING:
                rdata[3:0] = virtual_phase_routing_r;
            default:
                rdata = bmpr_pkg::BMPR_UNMAPPED_READ;
        endcase
    end

    assign reg_bus.rdata = rdata;

    // supply and output sequencing
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            gate_drive_supply_on_r <= 1'b0;
            boost_output_one_on_r <= 1'b0;
            boost_output_two_on_r <= 1'b0;
            battery_monitor_on_r <= 1'b0;
        end
        else if (i_clk_en)
        begin
            gate_drive_supply_on_r <= running && (output_one_turn_on_r || output_two_turn_on_r);
            boost_output_one_on_r <= running && output_one_turn_on_r && i_gate_supply_good;
            boost_output_two_on_r <= running && output_two_turn_on_r && i_gate_supply_good;
            battery_monitor_on_r <= running && i_gate_supply_good
                && (output_one_turn_on_r || output_two_turn_on_r);
        end
    end

    // per gate driver: virtual phase pick, its output, its enable
    for (genvar g = 0; g < bmpr_pkg::BMPR_NUM_GATES; g++)
    begin : gen_gate
        logic [1:0] pick;
        logic [3:0] enables;
        logic out_on;
        logic drive_nxt;

        assign pick = virtual_phase_routing_r[g * bmpr_pkg::BMPR_PICK_W +: bmpr_pkg::BMPR_PICK_W];
        assign enables = gate_phase_output_assign_r[g] ? virtual_phase_enable_out_two_r
                                                       : virtual_phase_enable_out_one_r;
        assign out_on = gate_output_association_r[g] ? boost_output_two_on_r : boost_output_one_on_r;
        assign drive_nxt = running && gate_driver_activate_r[g] && out_on
            && enables[pick] && i_vphase[pick];

        always_ff @(posedge i_core_clk or posedge i_rst)
        begin
            if (i_rst)
                gate_drive_r[g] <= 1'b0;
            else if (i_clk_en)
                gate_drive_r[g] <= drive_nxt;
        end
    end

    assign o_mode = mode_r;
    assign o_gate_drive_supply_on = gate_drive_supply_on_r;
    assign o_boost_output_one_on = boost_output_one_on_r;
    assign o_boost_output_two_on = boost_output_two_on_r;
    assign o_battery_monitor_on = battery_monitor_on_r;
    assign o_gate_drive = gate_drive_r;

endmodule : bmpr_top

/* File: dv/bmpr_chk.sv */
module bmpr_chk
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_supply_detect,
    input wire logic i_chip_activate,
    input wire logic i_over_temp,
    input wire logic i_gate_supply_err,
    input wire logic i_gate_supply_good,
    input wire logic i_input_undervolt,
    input wire logic i_input_overvolt,
    input wire logic o_spi_miso_oe,
    input wire logic [1:0] o_mode,
    input wire logic o_gate_drive_supply_on,
    input wire logic o_boost_output_one_on,
    input wire logic o_boost_output_two_on,
    input wire logic o_battery_monitor_on,
    input wire logic [1:0] o_gate_drive
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_power_up;
        o_mode == bmpr_pkg::BMPR_MODE_OFF && i_supply_detect && i_chip_activate;
    endsequence
    sequence s_run_fault;
        o_mode == bmpr_pkg::BMPR_MODE_RUN && i_supply_detect && i_chip_activate &&
            (i_over_temp || i_gate_supply_err || i_input_undervolt || i_input_overvolt);
    endsequence

    off_to_setup_a: assert property (s_power_up |=> o_mode == bmpr_pkg::BMPR_MODE_SETUP)
        else $error("setup mode not entered");
    power_loss_a: assert property (!(i_supply_detect && i_chip_activate) |=> o_mode == 2'h0)
        else $error("off mode not entered");
    fault_quiet_a: assert property (s_run_fault |=> o_mode == bmpr_pkg::BMPR_MODE_QUIET)
        else $error("quiet mode not entered on fault");
    quiet_dark_a: assert property (o_mode == 2'h2 && $past(o_mode) == 2'h2 |->
        o_gate_drive == 2'h0 && !o_boost_output_one_on && !o_boost_output_two_on && !o_gate_drive_supply_on)
        else $error("outputs live in quiet mode");
    supply_run_a: assert property (o_gate_drive_supply_on |-> $past(o_mode) == 2'h3)
        else $error("gate supply on outside running");
    boost_good_a: assert property (o_boost_output_one_on || o_boost_output_two_on |->
        $past(i_gate_supply_good) && $past(o_mode) == 2'h3)
        else $error("boost on without gate supply good");
    battery_run_a: assert property (o_battery_monitor_on == (o_boost_output_one_on || o_boost_output_two_on))
        else $error("battery monitor mismatch");
    gate_cause_a: assert property (|o_gate_drive |->
        $past(o_mode) == 2'h3 && $past(o_boost_output_one_on || o_boost_output_two_on))
        else $error("gate switched without cause");
    spi_off_a: assert property (o_mode == 2'h0 |-> !o_spi_miso_oe)
        else $error("miso driven in off mode");
endmodule : bmpr_chk

/* File: dv/bmpr_spi_host.sv */
module bmpr_spi_host
(
    input wire logic i_core_clk,
    input wire logic i_miso,
    output logic o_sclk = 1'b0,
    output logic o_cs_n = 1'b1,
    output logic o_mosi = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;

    // three core clocks per half period keeps above the two-clock minimum
    task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wd, output logic [7:0] rd);
        logic [15:0] frame;
        int i;
        frame = {wr, addr, wd};
        rd = 8'h00;
        @(posedge i_core_clk);
        o_cs_n <= 1'b0;
        for (i = 15; i >= 0; i--)
        begin
            o_mosi <= frame[i];
            repeat (3) @(posedge i_core_clk);
            if (i < 8)
                rd = {rd[6:0], i_miso};
            o_sclk <= 1'b1;
            repeat (3) @(posedge i_core_clk);
            o_sclk <= 1'b0;
        end
        repeat (2) @(posedge i_core_clk);
        o_cs_n <= 1'b1;
        // released line must not keep showing the last bit
        o_mosi <= ~frame[0];
    endtask : xfer
endmodule : bmpr_spi_host

/* File: dv/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic i_core_clk = 1'b0, i_rst = 1'b1, i_supply_detect = 1'b0, i_chip_activate = 1'b0, clk_en = 1'b1;
    logic i_over_temp = 1'b0, i_gate_supply_err = 1'b0, i_input_undervolt = 1'b0, i_input_overvolt = 1'b0;
    logic i_gate_supply_good = 1'b0, o_spi_miso, o_spi_miso_oe, o_gate_drive_supply_on, o_battery_monitor_on;
    logic o_boost_output_one_on, o_boost_output_two_on, spi_sclk, spi_cs_n, spi_mosi;
    logic [3:0] i_vphase = 4'h0;
    logic [1:0] o_mode, o_gate_drive;
    int miscompares = 0, num_checks = 0, seed = 32'heafa3103, m_mode = 0;
    int m_reg [17];
    int cfg_addr [7] = '{1, 2, 11, 12, 15, 16, 5};
    int all_addr [9] = '{0, 1, 2, 3, 11, 12, 15, 16, 5};
    int it, k, v, f;
    wire logic [7:0] outs = {2'h0, o_gate_drive, o_battery_monitor_on, o_boost_output_two_on,
        o_boost_output_one_on, o_gate_drive_supply_on};

    always #12.5 i_core_clk = ~i_core_clk;

    bmpr_top bmpr_top_inst (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_clk_en(clk_en),
        .i_supply_detect(i_supply_detect), .i_chip_activate(i_chip_activate), .i_over_temp(i_over_temp),
        .i_gate_supply_err(i_gate_supply_err), .i_gate_supply_good(i_gate_supply_good),
        .i_input_undervolt(i_input_undervolt), .i_input_overvolt(i_input_overvolt), .i_vphase(i_vphase),
        .i_spi_sclk(spi_sclk), .i_spi_cs_n(spi_cs_n), .i_spi_mosi(spi_mosi), .o_spi_miso(o_spi_miso),
        .o_spi_miso_oe(o_spi_miso_oe), .o_mode(o_mode), .o_gate_drive_supply_on(o_gate_drive_supply_on),
        .o_boost_output_one_on(o_boost_output_one_on), .o_boost_output_two_on(o_boost_output_two_on),
        .o_battery_monitor_on(o_battery_monitor_on), .o_gate_drive(o_gate_drive));
    bmpr_spi_host bmpr_spi_host_inst (.i_core_clk(i_core_clk), .i_miso(o_spi_miso), .o_sclk(spi_sclk),
        .o_cs_n(spi_cs_n), .o_mosi(spi_mosi));

    task automatic test_done();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic int msk(input int a);
        case (a)
            0: return 7;
            1, 2, 15: return 3;
            11, 12, 16: return 15;
            default: return 0;
        endcase
    endfunction : msk

    function automatic logic [7:0] exp_out(input int v);
        int run, t1, t2, b1, b2, gd, g, pick, en;
        run = (m_mode == 3);
        t1 = (m_reg[0] >> 1) & 1;
        t2 = (m_reg[0] >> 2) & 1;
        b1 = run & t1 & i_gate_supply_good;
        b2 = run & t2 & i_gate_supply_good;
        gd = 0;
        for (g = 0; g < 2; g++)
        begin
            pick = (m_reg[16] >> (2 * g)) & 3;
            en = (((m_reg[15] >> g) & 1) ? m_reg[12] : m_reg[11]) >> pick;
            if (run & (m_reg[1] >> g) & ((((m_reg[2] >> g) & 1) ? b2 : b1)) & en & (v >> pick))
                gd |= 1 << g;
        end
        return 8'((gd << 4) | ((b1 | b2) << 3) | (b2 << 2) | (b1 << 1) | (run & (t1 | t2)));
    endfunction : exp_out

    task automatic wait_mode(input int m);
        int n;
        n = 0;
        while (o_mode !== 2'(m) && n < 8)
        begin
            @(posedge i_core_clk);
            #1;
            n++;
        end
        chk(8'(o_mode), 8'(m));
        if (o_mode !== 2'(m))
            test_done();
        m_mode = m;
    endtask : wait_mode

    task automatic wr(input int a, input int d);
        logic [7:0] rd;
        bmpr_spi_host_inst.xfer(1'b1, 7'(a), 8'(d), rd);
        // locked configuration and the off mode both drop the write
        if (m_mode != 0 && !(m_reg[0] & 1 && a inside {1, 2, 11, 12, 15, 16}))
            m_reg[a] = d & msk(a);
        if (a == 0 && m_mode == 1 && d & 1)
            m_mode = 3;
        if (a == 0 && m_mode == 3 && !(d & 1))
            m_mode = 1;
        repeat (3) @(posedge i_core_clk);
    endtask : wr

    task automatic rd_chk(input int a);
        logic [7:0] rd;
        bmpr_spi_host_inst.xfer(1'b0, 7'(a), 8'h00, rd);
        chk(rd, 8'(a == 3 ? m_mode * 2 + i_gate_supply_good : m_reg[a] & msk(a)));
    endtask : rd_chk

    initial
    begin
        repeat (60000) @(posedge i_core_clk);
        miscompares++;
        test_done();
    end

    initial
    begin
        repeat (8) @(posedge i_core_clk);
        i_rst <= 1'b0;
        @(posedge i_core_clk);
        #1;
        chk(outs, 8'h00);
        wr(1, 3);
        @(posedge i_core_clk);
        i_supply_detect <= 1'b1;
        i_chip_activate <= 1'b1;
        wait_mode(1);
        for (k = 0; k < 9; k++)
            rd_chk(all_addr[k]);
        for (it = 0; it < 4; it++)
        begin
            wr(0, 0);
            wait_mode(1);
            for (k = 0; k < 7; k++)
                wr(cfg_addr[k], $random(seed) & msk(cfg_addr[k]));
            for (k = 0; k < 9; k++)
                rd_chk(all_addr[k]);
            @(posedge i_core_clk);
            i_gate_supply_good <= it[0];
            wr(0, 7 - 2 * it[1]);
            wait_mode(3);
            wr(11, 15 - m_reg[11]);
            rd_chk(11);
            #1;
            chk(outs, exp_out(i_vphase));
            v = i_vphase;
            for (k = 0; k < 24; k++)
            begin
                @(posedge i_core_clk);
                i_vphase <= 4'($random(seed));
                clk_en <= k[0] | k[1];
                #1;
                chk(outs, exp_out(v));
                if (clk_en)
                    v = i_vphase;
            end
        end
        for (f = 0; f < 5; f++)
        begin
            @(posedge i_core_clk);
            i_chip_activate <= 1'b0;
            wait_mode(0);
            m_reg = '{default: 0};
            @(posedge i_core_clk);
            i_chip_activate <= 1'b1;
            wait_mode(1);
            rd_chk(1);
            wr(0, 7);
            wait_mode(3);
            @(posedge i_core_clk);
            {i_over_temp, i_gate_supply_err, i_input_undervolt, i_input_overvolt} <= 4'(1 << f);
            i_supply_detect <= (f != 4);
            wait_mode(f == 4 ? 0 : 2);
            repeat (2) @(posedge i_core_clk);
            #1;
            chk(outs, 8'h00);
            if (f < 4)
                rd_chk(0);
            @(posedge i_core_clk);
            {i_over_temp, i_gate_supply_err, i_input_undervolt, i_input_overvolt} <= 4'h0;
            i_supply_detect <= 1'b1;
        end
        test_done();
    end
endmodule : tb_top

bind bmpr_top bmpr_chk bmpr_chk_inst (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_supply_detect(i_supply_detect),
    .i_chip_activate(i_chip_activate), .i_over_temp(i_over_temp), .i_gate_supply_err(i_gate_supply_err),
    .i_gate_supply_good(i_gate_supply_good), .i_input_undervolt(i_input_undervolt),
    .i_input_overvolt(i_input_overvolt), .o_spi_miso_oe(o_spi_miso_oe), .o_mode(o_mode),
    .o_gate_drive_supply_on(o_gate_drive_supply_on), .o_boost_output_one_on(o_boost_output_one_on),
    .o_boost_output_two_on(o_boost_output_two_on), .o_battery_monitor_on(o_battery_monitor_on),
    .o_gate_drive(o_gate_drive));
